// ==== hdl/irq_low_pin_select.sv ====
// Pin selector for interrupt requests 0 to 7 with its register port.
// Assumes pin levels are asynchronous and that software keeps the switching order.
//
// The register addresses and the plain strobed port were left to the implementer.
`include "irq_low_pin_select_regs.svh"
module irq_low_pin_select
    import irq_low_pin_select_pkg::*;
(
    input  wire logic                       clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic [`IRQ_SEL_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]                 wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [7:0]                 rdata_o,
    input  wire logic [7:0]                 port1_pin_i,
    input  wire logic [7:0]                 port5_pin_i,
    input  wire logic [7:0]                 port1_drive_i,
    input  wire logic [7:0]                 port5_drive_i,
    input  wire logic [7:0]                 port1_drive_en_i,
    input  wire logic [7:0]                 port5_drive_en_i,
    output logic      [7:0]                 port1_level_o,
    output logic      [7:0]                 port5_level_o,
    output logic      [7:0]                 irq_req_o
);
    byte_t irq_low_pin_select;
    byte_t input_buffer_control;
    byte_t p1_meta;
    byte_t p1_sync;
    byte_t p5_meta;
    byte_t p5_sync;
    byte_t next_p1_level;
    byte_t next_p5_level;

    function automatic reg_id_t decode(input logic [`IRQ_SEL_ADDR_W-1:0] a);
        case (a)
            `IRQ_SEL_OFFSET: decode = REG_SELECT;
            `IRQ_BUF_OFFSET: decode = REG_BUFFER;
            `IRQ_REQ_OFFSET: decode = REG_REQUEST;
            default:         decode = REG_NONE;
        endcase
    endfunction

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            irq_low_pin_select <= `IRQ_SEL_RESET;
        end
        else if (wr_i && decode(addr_i) == REG_SELECT)
        begin
            irq_low_pin_select <= wdata_i;
        end
    end

    // Bit n of this register enables the input buffer of pin n on both ports.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            input_buffer_control <= `IRQ_BUF_RESET;
        end
        else if (wr_i && decode(addr_i) == REG_BUFFER)
        begin
            input_buffer_control <= wdata_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            p1_meta <= 8'h00;
            p1_sync <= 8'h00;
            p5_meta <= 8'h00;
            p5_sync <= 8'h00;
        end
        else
        begin
            p1_meta <= port1_pin_i;
            p1_sync <= p1_meta;
            p5_meta <= port5_pin_i;
            p5_sync <= p5_meta;
        end
    end

    // A driven pin is sensed at its own output value, as the pad loops back.
    // A disabled buffer reads low so no input function sees the pin.
    genvar n;
    generate
        for (n = 0; n < 8; n++)
        begin : g_pin
            always_comb
            begin
                next_p1_level[n] = input_buffer_control[n] &
                    (port1_drive_en_i[n] ? port1_drive_i[n] : p1_sync[n]);
                next_p5_level[n] = input_buffer_control[n] &
                    (port5_drive_en_i[n] ? port5_drive_i[n] : p5_sync[n]);
            end
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            port1_level_o <= 8'h00;
            port5_level_o <= 8'h00;
        end
        else
        begin
            port1_level_o <= next_p1_level;
            port5_level_o <= next_p5_level;
        end
    end

    // The select steers the mux with no register in between, so a switch between pins
    // of different level shows as an edge; software must gate the request meanwhile.
    generate
        for (n = 0; n < 8; n++)
        begin : g_irq
            assign irq_req_o[n] = irq_low_pin_select[n] ?
                port5_level_o[n] : port1_level_o[n];
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (rd_i)
        begin
            case (decode(addr_i))
                REG_SELECT:  rdata_o <= irq_low_pin_select;
                REG_BUFFER:  rdata_o <= input_buffer_control;
                REG_REQUEST: rdata_o <= irq_req_o;
                default:     rdata_o <= `IRQ_UNMAPPED_DATA;
            endcase
        end
        else
        begin
            rdata_o <= 8'h00;
        end
    end

    a_select_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_i && decode(addr_i) == REG_SELECT |=> irq_low_pin_select == $past(wdata_i))
        else $error("select register did not take written value");
    a_a_side_route: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        irq_low_pin_select[0] == 1'b0 |-> irq_req_o[0] == port1_level_o[0])
        else $error("request 0 not routed from port 1");
    a_b_side_route: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        irq_low_pin_select[7] |-> irq_req_o[7] == port5_level_o[7])
        else $error("request 7 not routed from port 5");
    a_mux_full: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        irq_req_o == ((irq_low_pin_select & port5_level_o) |
                      (~irq_low_pin_select & port1_level_o)))
        else $error("request mux mismatch");
    a_level_sync: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        input_buffer_control[3] ##1 input_buffer_control[3] && !port1_drive_en_i[3]
        |=> port1_level_o[3] == $past(p1_sync[3]))
        else $error("port 1 level not presented");
    a_drive_loop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        input_buffer_control[0] && port1_drive_en_i[0]
        |=> port1_level_o[0] == $past(port1_drive_i[0]))
        else $error("driven value not sensed");
    a_buffer_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !input_buffer_control[1] |=> !port1_level_o[1] && !port5_level_o[1])
        else $error("disabled buffer passed a level");
    a_read_select: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_i && !wr_i && decode(addr_i) == REG_SELECT |=> rdata_o == $past(irq_low_pin_select))
        else $error("select readback wrong");
    a_switch_edge: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $changed(irq_low_pin_select[4]) && port1_level_o[4] != port5_level_o[4]
        && $stable(port1_level_o[4]) && $stable(port5_level_o[4]) |-> $changed(irq_req_o[4]))
        else $error("pin switch gave no edge");

    // The route, level, drive, buffer and switch checks above sample single bits; the loop below repeats them on every line,
    // so a swapped or stuck mux bit cannot hide behind the chosen samples.
    generate
        for (n = 0; n < 8; n++)
        begin : g_chk
            a_route_a_each: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                !irq_low_pin_select[n] |-> irq_req_o[n] == port1_level_o[n])
                else $error("request line not routed from port 1");

            a_route_b_each: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                irq_low_pin_select[n] |-> irq_req_o[n] == port5_level_o[n])
                else $error("request line not routed from port 5");

            a_buffer_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                !input_buffer_control[n] |=> !port1_level_o[n] && !port5_level_o[n])
                else $error("disabled buffer passed a level");

            a_loop_p1: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                input_buffer_control[n] && port1_drive_en_i[n]
                |=> port1_level_o[n] == $past(port1_drive_i[n]))
                else $error("port 1 driven value not sensed");

            a_loop_p5: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                input_buffer_control[n] && port5_drive_en_i[n]
                |=> port5_level_o[n] == $past(port5_drive_i[n]))
                else $error("port 5 driven value not sensed");

            a_pin_p1: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                input_buffer_control[n] && !port1_drive_en_i[n]
                |=> port1_level_o[n] == $past(p1_sync[n]))
                else $error("port 1 pin level not presented");

            a_pin_p5: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                input_buffer_control[n] && !port5_drive_en_i[n]
                |=> port5_level_o[n] == $past(p5_sync[n]))
                else $error("port 5 pin level not presented");

            a_switch_each: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                $changed(irq_low_pin_select[n]) && port1_level_o[n] != port5_level_o[n]
                && $stable(port1_level_o[n]) && $stable(port5_level_o[n])
                |-> $changed(irq_req_o[n]))
                else $error("pin switch gave no edge on a request line");
        end
    endgenerate

    // Register accesses are two-step behaviours: a strobe edge, then the effect
    // one cycle later. Naming the strobes keeps the properties short.
    sequence s_select_write;
        wr_i && decode(addr_i) == REG_SELECT;
    endsequence

    sequence s_buffer_write;
        wr_i && decode(addr_i) == REG_BUFFER;
    endsequence

    sequence s_buffer_read;
        rd_i && decode(addr_i) == REG_BUFFER;
    endsequence

    sequence s_request_read;
        rd_i && decode(addr_i) == REG_REQUEST;
    endsequence

    sequence s_unmapped_read;
        rd_i && decode(addr_i) == REG_NONE;
    endsequence

    // The new steering must show in the very next cycle; an added register stage
    // would delay it and break the switching order that software relies on.
    a_steer_latency: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_select_write |=> irq_req_o == ((port5_level_o & $past(wdata_i)) |
                                         (port1_level_o & ~$past(wdata_i))))
        else $error("select write did not steer in the next cycle");

    a_select_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !(wr_i && decode(addr_i) == REG_SELECT) |=> $stable(irq_low_pin_select))
        else $error("select register changed without a write");

    a_buffer_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_buffer_write |=> input_buffer_control == $past(wdata_i))
        else $error("buffer register did not take written value");

    a_read_buffer: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_buffer_read |=> rdata_o == $past(input_buffer_control))
        else $error("buffer readback wrong");

    a_read_request: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_request_read |=> rdata_o == $past(irq_req_o))
        else $error("request readback wrong");

    a_read_unmapped: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_unmapped_read |=> rdata_o == `IRQ_UNMAPPED_DATA)
        else $error("unmapped read returned data");

    // Read data stands for one cycle only, so a stale value is never mistaken
    // for the answer to a later strobe.
    a_rdata_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data stood past its cycle");

    a_reset_values: assert property (@(posedge clk_i)
        sys_rst_i |=> irq_low_pin_select == `IRQ_SEL_RESET
        && input_buffer_control == `IRQ_BUF_RESET && rdata_o == 8'h00)
        else $error("reset did not clear the registers");

    // Only the second stage may feed logic; a short cut from the first stage would
    // let a metastable level reach the request lines.
    a_sync_stage: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        1'b1 |=> p1_sync == $past(p1_meta) && p5_sync == $past(p5_meta))
        else $error("pin synchroniser skipped a stage");
endmodule

// ==== hdl/irq_low_pin_select_regs.svh ====
// Register offsets and reset values of the low interrupt pin selector.
// Assumes a plain one-cycle register port with read data one cycle after the strobe.
`ifndef IRQ_LOW_PIN_SELECT_REGS_SVH
`define IRQ_LOW_PIN_SELECT_REGS_SVH
`define IRQ_SEL_ADDR_W      4
`define IRQ_SEL_OFFSET      4'h0
`define IRQ_BUF_OFFSET      4'h1
`define IRQ_REQ_OFFSET      4'h2
`define IRQ_SEL_RESET       8'h00
`define IRQ_BUF_RESET       8'h00
`define IRQ_UNMAPPED_DATA   8'h00
`endif

// ==== hdl/irq_low_pin_select_pkg.sv ====
// Types shared by the low interrupt pin selector.
// Assumes the register header supplies all offsets and reset values.
package irq_low_pin_select_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        REG_SELECT,
        REG_BUFFER,
        REG_REQUEST,
        REG_NONE
    } reg_id_t;
endpackage

// ==== verif/port_pin_model.sv ====
// Behavioural model of one eight-pin port pad ring facing the selector.
// Assumes the bench sets outside levels just after a rising clock edge.
module port_pin_model
    import irq_low_pin_select_pkg::*;
(
    input  wire logic  clk_i,
    input  wire byte_t ext_level_i,
    input  wire byte_t drive_i,
    input  wire byte_t drive_en_i,
    output byte_t      pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // A pad that the port drives shows its own output value, not the outside level.
    always_ff @(posedge clk_i)
    begin
        pin_o <= (drive_i & drive_en_i) | (ext_level_i & ~drive_en_i);
    end
endmodule

// ==== verif/irq_low_pin_select_tb.sv ====
// Self-checking bench for the low interrupt pin selector and its register port.
// Assumes the pin latency of three edges and one-cycle read data.
`include "irq_low_pin_select_regs.svh"
module irq_low_pin_select_tb
    import irq_low_pin_select_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    byte_t      wdata_i = 8'h00;
    byte_t      rdata_o, pin1, pin5, lvl1, lvl5, irq, m;
    byte_t      ext1 = 8'h00;
    byte_t      ext5 = 8'h00;
    byte_t      drv1 = 8'h00;
    byte_t      en1 = 8'h00;
    int         fail_count = 0;
    int         checks_done = 0;

    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    port_pin_model p1_i (.clk_i(clk_i), .ext_level_i(ext1), .drive_i(drv1),
        .drive_en_i(en1), .pin_o(pin1));
    port_pin_model p5_i (.clk_i(clk_i), .ext_level_i(ext5), .drive_i(8'h00),
        .drive_en_i(8'h00), .pin_o(pin5));
    irq_low_pin_select irq_low_pin_select_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .port1_pin_i(pin1), .port5_pin_i(pin5), .port1_drive_i(drv1),
        .port5_drive_i(8'h00), .port1_drive_en_i(en1), .port5_drive_en_i(8'h00),
        .port1_level_o(lvl1), .port5_level_o(lvl5), .irq_req_o(irq));

    task automatic check(input byte_t got, input byte_t exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input byte_t d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input byte_t exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask

    task automatic finish_test();
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog: the sequence below is short, so a run this long means a hang.
    initial
    begin
        repeat (3000) @(posedge clk_i);
        fail_count++;
        finish_test();
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(`IRQ_SEL_OFFSET, `IRQ_SEL_RESET);
        ext1 <= 8'h5a;
        ext5 <= 8'ha5;
        wr(`IRQ_SEL_OFFSET, 8'h00);
        wr(`IRQ_BUF_OFFSET, 8'hff);
        repeat (5) @(posedge clk_i);
        #1;
        check(lvl1, 8'h5a);
        check(lvl5, 8'ha5);
        check(irq, 8'h5a);
        wr(`IRQ_SEL_OFFSET, 8'hff);
        check(irq, 8'ha5);
        for (int n = 0; n < 8; n++)
        begin
            m = 8'h01 << n;
            wr(`IRQ_SEL_OFFSET, m);
            check(irq, (8'h5a & ~m) | (8'ha5 & m));
            rd(`IRQ_SEL_OFFSET, m);
        end
        rd(`IRQ_REQ_OFFSET, 8'hda);
        wr(4'h7, 8'hff);
        rd(4'h7, `IRQ_UNMAPPED_DATA);
        rd(`IRQ_SEL_OFFSET, 8'h80);
        en1 <= 8'h0f;
        drv1 <= 8'h03;
        repeat (5) @(posedge clk_i);
        #1;
        check(lvl1, 8'h53);
        check(irq, 8'hd3);
        wr(`IRQ_BUF_OFFSET, 8'h00);
        repeat (5) @(posedge clk_i);
        #1;
        check(lvl1 | lvl5 | irq, 8'h00);
        finish_test();
    end
endmodule
